// file: shared/por_seq_regs.svh
`ifndef POR_SEQ_REGS_SVH
`define POR_SEQ_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS      32'd4000
`define CONFIG_TIME_US     32'd450
`define IO_SETTLE_TIME_US  32'd2
`define US_TO_PS           32'd1000000
`define CONFIG_CYCLES      ((`CONFIG_TIME_US * `US_TO_PS) / `CLK_PERIOD_PS)
`define IO_SETTLE_CYCLES   ((`IO_SETTLE_TIME_US * `US_TO_PS) / `CLK_PERIOD_PS)
`define CNT_WIDTH          18
`define CNT_ZERO           18'h00000
`define CNT_ONE            18'h00001

// ----------------------------------------------------------------
// Variants
// ----------------------------------------------------------------
`define VAR_BASE           2'h0
`define VAR_LOW_VOLT       2'h1
`define VAR_ZERO_POWER     2'h2

`endif

// file: shared/por_seq_pkg.sv
package por_seq_pkg;
    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_OFF      = 6'h01,  // Core below threshold
        ST_COPY     = 6'h02,  // Configuration copy running
        ST_WAIT_IO  = 6'h04,  // Copy done, waiting on banks
        ST_SETTLE   = 6'h08,  // Late banks settling
        ST_CLEAR    = 6'h10,  // Register clear release
        ST_USER     = 6'h20   // User mode
    } seq_state_type;
    typedef logic [1:0] variant_type;
endpackage

// file: rtl/por_interval_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "por_seq_regs.svh"

// ----------------------------------------------------------------
// Interval counter: loads, counts down, flags zero
// ----------------------------------------------------------------
module por_interval_timer (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    // Control
    input  wire logic                    load,
    input  wire logic [`CNT_WIDTH-1:0]   load_value,
    // Status
    output logic                         expired
);
    logic [`CNT_WIDTH-1:0] count_reg;   // Cycles left
    logic [`CNT_WIDTH-1:0] count_next;  // Next count

    // Hold at zero once run out
    assign count_next = load ? load_value :
                        (count_reg == `CNT_ZERO) ? `CNT_ZERO : count_reg - `CNT_ONE;
    assign expired    = (count_reg == `CNT_ZERO) && !load;

    // Counter register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_reg <= `CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // por_interval_timer

`default_nettype wire

// file: rtl/power_on_reset_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "por_seq_regs.svh"

// ----------------------------------------------------------------
// Power-on reset sequencer
// ----------------------------------------------------------------
module power_on_reset_sequencer (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // Variant strap
    input  wire por_seq_pkg::variant_type variant,
    // Supply-good flags, synchronous
    input  wire logic                     core_above_start,
    input  wire logic                     core_above_sag,
    input  wire logic                     io_banks_good,
    input  wire logic                     pad_over_io,
    // Device-wide pins and their options
    input  wire logic                     clear_pin_enabled,
    input  wire logic                     device_wide_clear_pin_n,
    input  wire logic                     oe_pin_enabled,
    input  wire logic                     device_wide_output_enable_pin,
    // Configuration copy from the flash block
    output logic                          config_flash_block_copy,
    input  wire logic                     config_copy_done,
    // Reset and pin control
    output logic                          sram_reset,
    output logic                          user_regs_clear,
    output logic                          io_tristate,
    output logic                          io_weak_pullup,
    output logic                          hot_insert_guard,
    output logic                          user_mode
);
    import por_seq_pkg::*;

    // ------------------------------------------------------------
    // State and timing
    // ------------------------------------------------------------
    seq_state_type          state_reg;      // Sequencer state
    seq_state_type          state_next;     // Next state
    logic                   late_io_reg;    // Banks missed the window
    logic                   late_io_next;   // Next late flag
    logic                   timer_load;     // Reload interval timer
    logic [`CNT_WIDTH-1:0]  timer_value;    // Value to load
    logic                   timer_expired;  // Interval elapsed
    logic                   watch_core;     // Brown-out watch active
    logic                   brown_out;      // Core sag seen
    logic                   power_bad;      // Any supply unsafe
    logic                   core_good;      // Core clear of sag level

    // Cycle counts derived from times; both fit the counter width
    localparam logic [`CNT_WIDTH-1:0] CONFIG_CNT = `CNT_WIDTH'(`CONFIG_CYCLES);
    localparam logic [`CNT_WIDTH-1:0] SETTLE_CNT = `CNT_WIDTH'(`IO_SETTLE_CYCLES);

    // ------------------------------------------------------------
    // Supply decoding
    // ------------------------------------------------------------
    // Zero-power part ignores core sag once in user mode
    assign watch_core = (variant != `VAR_ZERO_POWER);
    // Core threshold stands for 1.7 V or 1.55 V per variant
    assign core_good  = core_above_sag;
    // Sag at or below the lower level counts as brown-out
    assign brown_out  = watch_core && !core_good;
    // Either supply low or pad above bank means drivers stay off
    assign power_bad  = !core_above_start || !io_banks_good || pad_over_io;

    // ------------------------------------------------------------
    // Timer
    // ------------------------------------------------------------
    por_interval_timer u_timer (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .load       (timer_load),
        .load_value (timer_value),
        .expired    (timer_expired)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        late_io_next = late_io_reg;
        timer_load   = 1'b0;
        timer_value  = CONFIG_CNT;
        unique case (state_reg)
            ST_OFF: begin
                // Copy launches on core threshold only
                late_io_next = 1'b0;
                if (core_above_start) begin
                    state_next = ST_COPY;
                    timer_load = 1'b1;
                end
            end
            ST_COPY: begin
                // Core loss during copy starts over
                if (!core_above_sag) begin
                    state_next = ST_OFF;
                end else if (config_copy_done) begin
                    state_next = ST_WAIT_IO;
                end
            end
            ST_WAIT_IO: begin
                // Configuration window running out marks banks late
                if (!core_above_sag) begin
                    state_next = ST_OFF;
                end else if (timer_expired && !io_banks_good) begin
                    late_io_next = 1'b1;
                end else if (io_banks_good) begin
                    if (late_io_reg) begin
                        state_next  = ST_SETTLE;
                        timer_load  = 1'b1;
                        timer_value = SETTLE_CNT;
                    end else begin
                        state_next = ST_CLEAR;
                    end
                end
            end
            ST_SETTLE: begin
                // Bank drop restarts the settle wait
                if (!core_above_sag) begin
                    state_next = ST_OFF;
                end else if (!io_banks_good) begin
                    state_next = ST_WAIT_IO;
                end else if (timer_expired) begin
                    state_next = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                // One cycle of clear before pins are released
                state_next = core_above_sag ? ST_USER : ST_OFF;
            end
            ST_USER: begin
                // Core sag is watched except on the zero-power part; never the banks
                if (brown_out) begin
                    state_next = ST_OFF;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg   <= ST_OFF;
            late_io_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            late_io_reg <= late_io_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    // Pins stay tri-stated until user mode, or longer under the
    // output enable pin option; clears may be held by the clear pin.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            config_flash_block_copy <= 1'b0;
            sram_reset              <= 1'b1;
            user_regs_clear         <= 1'b1;
            io_tristate             <= 1'b1;
            io_weak_pullup          <= 1'b1;
            hot_insert_guard        <= 1'b1;
            user_mode               <= 1'b0;
        end else begin
            config_flash_block_copy <= (state_next == ST_COPY);
            sram_reset              <= (state_next == ST_OFF);
            // Clear drops in the CLEAR cycle, one cycle ahead of the pins
            user_regs_clear         <= !((state_next == ST_USER) || (state_next == ST_CLEAR)) ||
                                       (clear_pin_enabled && !device_wide_clear_pin_n);
            io_tristate             <= (state_next != ST_USER) ||
                                       (oe_pin_enabled && !device_wide_output_enable_pin) ||
                                       power_bad;
            io_weak_pullup          <= (state_next != ST_USER);
            hot_insert_guard        <= power_bad;
            user_mode               <= (state_next == ST_USER);
        end
    end
endmodule // power_on_reset_sequencer

`default_nettype wire

// file: verif/por_seq_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the reset sequencer
// ----------------------------------------------------------------
module por_seq_checker (
    // Clock and reset
    input wire logic                     mclk,
    input wire logic                     rst_n,
    // Strap and supply flags
    input wire por_seq_pkg::variant_type variant,
    input wire logic                     core_above_start,
    input wire logic                     core_above_sag,
    input wire logic                     io_banks_good,
    input wire logic                     pad_over_io,
    // Device-wide pins
    input wire logic                     clear_pin_enabled,
    input wire logic                     device_wide_clear_pin_n,
    input wire logic                     oe_pin_enabled,
    input wire logic                     device_wide_output_enable_pin,
    // Copy handshake
    input wire logic                     config_flash_block_copy,
    input wire logic                     config_copy_done,
    // Outputs under watch
    input wire logic                     sram_reset,
    input wire logic                     user_regs_clear,
    input wire logic                     io_tristate,
    input wire logic                     io_weak_pullup,
    input wire logic                     hot_insert_guard,
    input wire logic                     user_mode
);
    // One domain, so one clock and one disable for all
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_start; sram_reset && core_above_start && core_above_sag |=> config_flash_block_copy;
    endproperty
    a_start: assert property (p_start) else $error("copy not started");
    property p_boot; config_flash_block_copy && config_copy_done && io_banks_good
        && core_above_sag && !pad_over_io && !oe_pin_enabled
        |=> !config_flash_block_copy ##2 (user_mode && !io_tristate); endproperty
    a_boot: assert property (p_boot) else $error("late user entry");
    property p_hold; !user_mode |-> io_tristate && io_weak_pullup; endproperty
    a_hold: assert property (p_hold) else $error("pins free before user");
    property p_order; $fell(io_tristate) && !clear_pin_enabled |-> !$past(user_regs_clear);
    endproperty
    a_order: assert property (p_order) else $error("clear after pins");
    property p_sag; user_mode && !core_above_sag && variant != 2'h2 |=> sram_reset && !user_mode;
    endproperty
    a_sag: assert property (p_sag) else $error("sag ignored");
    property p_zp; user_mode && variant == 2'h2 |=> user_mode; endproperty
    a_zp: assert property (p_zp) else $error("zero-power left user");
    property p_core_only; user_mode && core_above_sag |=> user_mode; endproperty
    a_core_only: assert property (p_core_only) else $error("left user on banks");
    property p_guard; pad_over_io || !io_banks_good |=> hot_insert_guard && io_tristate;
    endproperty
    a_guard: assert property (p_guard) else $error("drivers on when unsafe");
    property p_oe; oe_pin_enabled && !device_wide_output_enable_pin |=> io_tristate; endproperty
    a_oe: assert property (p_oe) else $error("oe hold lost");
    // Main scenarios reached
    c_user: cover property ($rose(user_mode));
    c_drop: cover property ($fell(user_mode));
    c_guard: cover property (user_mode && hot_insert_guard);
endmodule // por_seq_checker
`default_nettype wire

// file: verif/flash_copy_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Flash block model: answers a copy after a fixed time
// ----------------------------------------------------------------
module flash_copy_model #(
    parameter int COPY_CYCLES = 40  // Short copy keeps runs brief
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic config_flash_block_copy,
    output logic      config_copy_done
);
    int count_reg;  // Cycles spent copying
    // Done is a level; it drops as soon as the request goes
    always_ff @(posedge mclk) begin
        if (!rst_n || !config_flash_block_copy) begin
            count_reg <= 0;
            config_copy_done <= 1'b0;
        end else begin
            count_reg <= count_reg + 1;
            config_copy_done <= (count_reg >= COPY_CYCLES - 1);
        end
    end
endmodule // flash_copy_model
`default_nettype wire

// file: verif/test_power_on_reset_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_power_on_reset_sequencer;
    import por_seq_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    variant_type variant = 2'h0;
    logic        core_above_start = 1'b0, core_above_sag = 1'b0, io_banks_good = 1'b0;
    logic        pad_over_io = 1'b0, clear_pin_enabled = 1'b0, device_wide_clear_pin_n = 1'b1;
    logic        oe_pin_enabled = 1'b0, device_wide_output_enable_pin = 1'b0;
    logic        config_flash_block_copy, config_copy_done, sram_reset, user_regs_clear;
    logic        io_tristate, io_weak_pullup, hot_insert_guard, user_mode;
    int          n_fail = 0;
    int          samples_checked = 0;
    always #2 mclk = ~mclk;
    power_on_reset_sequencer dut (.*);
    flash_copy_model fm (.*);
    // Step n edges, then settle 1 ns past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait for user mode
    task automatic wait_user(input int lim);
        for (int i = 0; i < lim && user_mode !== 1'b1; i++) tick(1);
        chk(user_mode, 1'b1);
    endtask
    // All supplies off, options off, strap set under reset
    task automatic power_off(input variant_type v, input int n);
        rst_n = 1'b0;
        variant = v;
        {core_above_start, core_above_sag, io_banks_good, pad_over_io} = 4'h0;
        {clear_pin_enabled, oe_pin_enabled, device_wide_output_enable_pin} = 3'h0;
        device_wide_clear_pin_n = 1'b1;
        tick(n);
        rst_n = 1'b1;
        tick(1);
    endtask
    // Supplies rise together
    task automatic s_boot(input variant_type v);
        power_off(v, 2);
        chk(io_tristate, 1'b1);
        {core_above_sag, core_above_start, io_banks_good} = 3'h7;
        tick(2);
        chk(config_flash_block_copy, 1'b1);
        chk(sram_reset, 1'b0);
        chk(io_weak_pullup, 1'b1);
        wait_user(112500);
        chk(io_tristate, 1'b0);
        chk(io_weak_pullup, 1'b0);
        chk(user_regs_clear, 1'b0);
    endtask
    // Brown-out and recovery
    task automatic s_brown(input variant_type v);
        s_boot(v);
        {core_above_start, core_above_sag} = 2'h0;
        tick(2);
        chk(user_mode, 1'b0);
        chk(sram_reset, 1'b1);
        chk(io_tristate, 1'b1);
        {core_above_start, core_above_sag} = 2'h3;
        wait_user(112500);
    endtask
    // Zero-power part ignores a sag once running
    task automatic s_zero;
        s_boot(2'h2);
        {core_above_start, core_above_sag} = 2'h0;
        tick(5);
        chk(user_mode, 1'b1);
        // Core pulled to 0 V for 10 us; dead logic is modelled as reset
        power_off(2'h2, 2500);
        {core_above_sag, core_above_start, io_banks_good} = 3'h7;
        wait_user(112500);
    endtask
    // Banks late but inside the window
    task automatic s_late;
        power_off(2'h0, 2);
        {core_above_sag, core_above_start} = 2'h3;
        tick(100);
        chk(user_mode, 1'b0);
        chk(io_tristate, 1'b1);
        io_banks_good = 1'b1;
        wait_user(20);
    endtask
    // Clear and output enable pin options
    task automatic s_pins;
        power_off(2'h0, 2);
        {clear_pin_enabled, oe_pin_enabled, device_wide_clear_pin_n} = 3'h6;
        {core_above_sag, core_above_start, io_banks_good} = 3'h7;
        wait_user(112500);
        tick(5);
        chk(io_tristate, 1'b1);
        chk(user_regs_clear, 1'b1);
        device_wide_clear_pin_n = 1'b1;
        tick(2);
        chk(user_regs_clear, 1'b0);
        device_wide_output_enable_pin = 1'b1;
        tick(2);
        chk(io_tristate, 1'b0);
    endtask
    // Pad spike and bank loss while running
    task automatic s_hot;
        s_boot(2'h1);
        pad_over_io = 1'b1;
        tick(2);
        chk(io_tristate, 1'b1);
        pad_over_io = 1'b0;
        io_banks_good = 1'b0;
        tick(2);
        chk(hot_insert_guard, 1'b1);
        chk(user_mode, 1'b1);
        io_banks_good = 1'b1;
        tick(2);
        chk(io_tristate, 1'b0);
    endtask
    task automatic close_out;
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        power_off(2'h0, 16);
        s_brown(2'h0);
        s_brown(2'h1);
        s_zero;
        s_late;
        s_pins;
        s_hot;
        close_out;
    end
    // Hang guard, far beyond the expected few thousand cycles
    initial begin
        #200000;
        n_fail++;
        close_out;
    end
endmodule // test_power_on_reset_sequencer
bind power_on_reset_sequencer por_seq_checker chk (.*);
`default_nettype wire
